// ==== alpr_pkg.sv ====
package alpr_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_PARAM = 8'h84;
  localparam logic [7:0] ADDR_RES_HIGH = 8'h85;
  localparam logic [7:0] ADDR_RES_LOW = 8'h86;

  // Parameter register layout, bit 7 down to bit 0
  typedef struct packed {
    logic cont;
    logic [2:0] rate;
    logic aoc;
    logic [2:0] avg;
  } alpr_param_t;

  // Continuous off, 1 sample/s, offset compensation on, 32 conversions
  localparam logic [7:0] PARAM_RST = 8'h0D;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // Clock rate and the one-second base of the sample period
  localparam int CLK_RATE_HZ = 50_000_000;
  localparam int SAMPLE_BASE_S = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OFFS = 2'b01,
    ST_CONV = 2'b10,
    ST_DONE = 2'b11
  } alpr_state_t;

  // Samples per second for each rate code
  function automatic int rate_sps(input logic [2:0] code);
    case (code)
      3'h0: rate_sps = 1;
      3'h1: rate_sps = 2;
      3'h2: rate_sps = 3;
      3'h3: rate_sps = 4;
      3'h4: rate_sps = 5;
      3'h5: rate_sps = 6;
      3'h6: rate_sps = 8;
      default: rate_sps = 10;
    endcase
  endfunction

endpackage

// ==== alpr_ambient.sv ====
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Bit 7 continuous mode, reset zero
// - Bit 3 offset compensation, reset one
// - Offset measured first, then subtracted
// - Average of 2^n conversions per cycle
// - Averaging field resets to 101
// - Written settings wait until self-timed is disabled
// - Result high at 85h, low at 86h
// - On-demand trigger ignored while self-timed enabled
module alpr_ambient #(
  parameter int CLK_HZ = alpr_pkg::CLK_RATE_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Command bits from the command register
  input wire logic selftimed_en,
  input wire logic ambient_on_demand_trigger,
  // Converter
  output logic conv_req,
  output logic conv_offset,
  input wire logic raw_valid,
  input wire logic [15:0] raw_data,
  // Status
  output logic busy,
  output logic result_ready
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Constant divisors only, so no divider is built
  function automatic logic [25:0] period_cycles(input logic [2:0] code);
    case (code)
      3'h0: period_cycles = 26'(CLK_HZ * alpr_pkg::SAMPLE_BASE_S / 1);
      3'h1: period_cycles = 26'(CLK_HZ * alpr_pkg::SAMPLE_BASE_S / 2);
      3'h2: period_cycles = 26'(CLK_HZ * alpr_pkg::SAMPLE_BASE_S / 3);
      3'h3: period_cycles = 26'(CLK_HZ * alpr_pkg::SAMPLE_BASE_S / 4);
      3'h4: period_cycles = 26'(CLK_HZ * alpr_pkg::SAMPLE_BASE_S / 5);
      3'h5: period_cycles = 26'(CLK_HZ * alpr_pkg::SAMPLE_BASE_S / 6);
      3'h6: period_cycles = 26'(CLK_HZ * alpr_pkg::SAMPLE_BASE_S / 8);
      default: period_cycles = 26'(CLK_HZ * alpr_pkg::SAMPLE_BASE_S / 10);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  alpr_pkg::alpr_param_t param_r;
  alpr_pkg::alpr_param_t act_r;
  alpr_pkg::alpr_state_t state_r, state_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [15:0] result_r, result_nxt;
  logic [15:0] offset_r, offset_nxt;
  logic [22:0] acc_r, acc_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [25:0] period_r, period_nxt;
  logic conv_req_r, conv_req_nxt;
  logic conv_offset_r, conv_offset_nxt;
  logic ready_r, loop_r, busy_r, first_r;

  wire logic wr_param = wr & hit(addr, alpr_pkg::ADDR_PARAM);
  wire logic rd_high = rd & hit(addr, alpr_pkg::ADDR_RES_HIGH);
  wire logic rd_low = rd & hit(addr, alpr_pkg::ADDR_RES_LOW);
  wire logic rd_param = rd & hit(addr, alpr_pkg::ADDR_PARAM);

  // Unmapped addresses read zero
  assign rdata_nxt = rd_param ? param_r :
                     rd_high ? result_r[15:8] :
                     rd_low ? result_r[7:0] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Self-timed sample clock; restarts at zero so enabling fires at once
  wire logic tick = selftimed_en & (period_r == 26'h0);
  assign period_nxt = !selftimed_en ? 26'h0 :
                      tick ? period_cycles(act_r.rate) - 26'h1 :
                      period_r - 26'h1;

  // On-demand and continuous restart are shut out in self-timed mode
  wire logic od_start = !selftimed_en & (ambient_on_demand_trigger |
                                         (act_r.cont & loop_r));
  wire logic start = tick | od_start;

  wire logic [7:0] target = 8'h01 << act_r.avg;
  wire logic [7:0] cnt_inc = cnt_r + 8'h01;
  wire logic [22:0] acc_add = acc_r + {7'h00, raw_data};
  wire logic [15:0] avg_val = 16'(acc_r >> act_r.avg);
  // Clamp at zero rather than wrap when offset exceeds reading
  wire logic use_off = act_r.aoc;
  wire logic [15:0] comp_val = !use_off ? avg_val :
                               (avg_val > offset_r) ? avg_val - offset_r :
                               16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    conv_req_nxt = 1'b0;
    conv_offset_nxt = conv_offset_r;
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    offset_nxt = offset_r;
    result_nxt = result_r;
    case (state_r)
      alpr_pkg::ST_IDLE: begin
        if (start) begin
          conv_req_nxt = 1'b1;
          cnt_nxt = 8'h00;
          acc_nxt = 23'h0;
          if (act_r.aoc) begin
            state_nxt = alpr_pkg::ST_OFFS;
            conv_offset_nxt = 1'b1;
          end else begin
            state_nxt = alpr_pkg::ST_CONV;
            conv_offset_nxt = 1'b0;
          end
        end
      end
      alpr_pkg::ST_OFFS: begin
        if (raw_valid) begin
          offset_nxt = raw_data;
          state_nxt = alpr_pkg::ST_CONV;
          conv_req_nxt = 1'b1;
          conv_offset_nxt = 1'b0;
        end
      end
      alpr_pkg::ST_CONV: begin
        if (raw_valid) begin
          acc_nxt = acc_add;
          cnt_nxt = cnt_inc;
          if (cnt_inc == target) begin
            state_nxt = alpr_pkg::ST_DONE;
          end else begin
            conv_req_nxt = 1'b1;
          end
        end
      end
      alpr_pkg::ST_DONE: begin
        result_nxt = comp_val;
        state_nxt = alpr_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = alpr_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      param_r <= alpr_pkg::PARAM_RST;
      act_r <= alpr_pkg::PARAM_RST;
    end else begin
      if (wr_param) begin
        param_r <= wdata;
      end
      // Running settings are frozen while the self-timed engine runs
      if (!selftimed_en) begin
        act_r <= param_r;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= alpr_pkg::ST_IDLE;
      result_r <= alpr_pkg::RESULT_RST;
      offset_r <= 16'h0000;
      acc_r <= 23'h0;
      cnt_r <= 8'h00;
      period_r <= 26'h0;
    end else begin
      state_r <= state_nxt;
      result_r <= result_nxt;
      offset_r <= offset_nxt;
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
      period_r <= period_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
      conv_req_r <= 1'b0;
      conv_offset_r <= 1'b0;
      ready_r <= 1'b0;
      loop_r <= 1'b0;
      busy_r <= 1'b0;
      first_r <= 1'b1;
    end else begin
      rdata_r <= rdata_nxt;
      conv_req_r <= conv_req_nxt;
      conv_offset_r <= conv_offset_nxt;
      ready_r <= (state_r == alpr_pkg::ST_DONE);
      loop_r <= (state_r == alpr_pkg::ST_DONE);
      busy_r <= (state_nxt != alpr_pkg::ST_IDLE);
      first_r <= 1'b0;
    end
  end

  assign rdata = rdata_r;
  assign conv_req = conv_req_r;
  assign conv_offset = conv_offset_r;
  assign busy = busy_r;
  assign result_ready = ready_r;

  ////////////////////////////////////////////////////////////////////////////
  // Guards on the register port, the run sequencer and the rate timer
  a_cont_bit_rw: assert property (@(posedge clk) disable iff (reset)
    wr_param |=> param_r.cont == $past(wdata[7]))
    else $error("continuous bit not stored");

  a_rate_reload: assert property (@(posedge clk) disable iff (reset)
    tick |=> period_r ==
    26'(CLK_HZ * alpr_pkg::SAMPLE_BASE_S / alpr_pkg::rate_sps($past(act_r.rate)) - 1))
    else $error("sample period reload wrong");

  a_aoc_bit_rw: assert property (@(posedge clk) disable iff (reset)
    wr_param |=> param_r.aoc == $past(wdata[3]))
    else $error("offset enable bit not stored");

  a_offset_first: assert property (@(posedge clk) disable iff (reset)
    (state_r == alpr_pkg::ST_IDLE && start && act_r.aoc)
    |=> conv_req_r && conv_offset_r && state_r == alpr_pkg::ST_OFFS)
    else $error("offset conversion not first");

  a_no_offset: assert property (@(posedge clk) disable iff (reset)
    (state_r == alpr_pkg::ST_IDLE && start && !act_r.aoc)
    |=> conv_req_r && !conv_offset_r && state_r == alpr_pkg::ST_CONV)
    else $error("offset conversion without compensation");

  a_avg_count: assert property (@(posedge clk) disable iff (reset)
    (state_r == alpr_pkg::ST_DONE) |-> cnt_r == (8'h01 << act_r.avg))
    else $error("wrong number of conversions averaged");

  a_avg_value: assert property (@(posedge clk) disable iff (reset)
    (state_r == alpr_pkg::ST_DONE && !act_r.aoc)
    |=> result_r == 16'($past(acc_r) >> $past(act_r.avg)))
    else $error("average value wrong");

  a_param_default: assert property (@(posedge clk) disable iff (reset)
    first_r |-> param_r == 8'h0D && act_r.avg == 3'b101)
    else $error("parameter reset value wrong");

  a_hold_pending: assert property (@(posedge clk) disable iff (reset)
    (selftimed_en && $past(selftimed_en)) |-> $stable(act_r))
    else $error("settings changed while self-timed");

  a_result_read: assert property (@(posedge clk) disable iff (reset)
    rd_high |=> rdata_r == $past(result_r[15:8]))
    else $error("high result byte misread");

  a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
    !rd |=> rdata_r == 8'h00)
    else $error("read data not cleared");

  a_od_blocked: assert property (@(posedge clk) disable iff (reset)
    (state_r == alpr_pkg::ST_IDLE && selftimed_en && !tick)
    |=> state_r == alpr_pkg::ST_IDLE && !conv_req_r)
    else $error("on-demand start while self-timed");

  a_cont_restart: assert property (@(posedge clk) disable iff (reset)
    (result_ready && act_r.cont && !selftimed_en) |=> conv_req_r)
    else $error("continuous run not restarted");

  a_result_atomic: assert property (@(posedge clk) disable iff (reset)
    (result_r != $past(result_r)) |-> $past(state_r == alpr_pkg::ST_DONE)
    ##0 result_ready)
    else $error("result changed outside completion");

  a_ready_pulse: assert property (@(posedge clk) disable iff (reset)
    result_ready |=> !result_ready)
    else $error("result ready longer than one cycle");

  // Covers for the main run shapes
  c_offset_run: cover property (@(posedge clk) disable iff (reset)
    conv_offset_r ##[1:20] result_ready);
  c_cont_loop: cover property (@(posedge clk) disable iff (reset)
    result_ready && act_r.cont ##1 conv_req_r);
  c_self_timed: cover property (@(posedge clk) disable iff (reset)
    tick ##1 conv_req_r);
  c_clamp_zero: cover property (@(posedge clk) disable iff (reset)
    state_r == alpr_pkg::ST_DONE && act_r.aoc && avg_val <= offset_r);
  c_avg_max: cover property (@(posedge clk) disable iff (reset)
    state_r == alpr_pkg::ST_DONE && act_r.avg == 3'h7);

endmodule

`default_nettype wire

// ==== alpr_conv_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module alpr_conv_model (
  // Clock
  input wire logic clk,
  // Converter handshake
  input wire logic conv_req,
  input wire logic conv_offset,
  output logic raw_valid,
  output logic [15:0] raw_data,
  // Scenario control
  input wire logic slow,
  input wire logic [15:0] offs_val,
  input wire logic [15:0] samp_val
);
  int wait_cnt = 0;
  logic dark_r = 1'b0;
  logic phase_r = 1'b0;
  initial begin
    raw_valid = 1'b0;
    raw_data = 16'h5A5A;
  end
  ////////////////////////////////////////////////////////////////////
  // Data toggles between answers so a stale sample never looks valid
  always @(posedge clk) begin
    raw_valid <= 1'b0;
    raw_data <= ~raw_data;
    if (conv_req === 1'b1) begin
      wait_cnt <= slow ? 6 : 1;
      dark_r <= conv_offset;
    end else if (wait_cnt == 1) begin
      raw_valid <= 1'b1;
      raw_data <= dark_r ? offs_val : samp_val + {14'h0000, phase_r, 1'b0};
      // Alternating samples make the average differ from any single one
      if (!dark_r) begin
        phase_r <= ~phase_r;
      end
      wait_cnt <= 0;
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule
`default_nettype wire

// ==== tb_ambient_light_param_result.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_ambient_light_param_result;
  // Short self-timed period keeps the run brief
  localparam int CLKHZ = 2000;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic st_en = 1'b0;
  logic trig = 1'b0;
  logic slow = 1'b0;
  logic [15:0] offs = 16'h0123;
  logic [15:0] samp = 16'h4320;
  logic [7:0] rdata;
  logic conv_req, conv_offset, raw_valid, busy, result_ready;
  logic [15:0] raw_data;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int nconv = 0;
  int nres = 0;
  alpr_ambient #(.CLK_HZ(CLKHZ)) u_dut (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .selftimed_en(st_en),
    .ambient_on_demand_trigger(trig), .conv_req(conv_req), .conv_offset(conv_offset),
    .raw_valid(raw_valid), .raw_data(raw_data), .busy(busy), .result_ready(result_ready));
  alpr_conv_model u_conv (.clk(clk), .conv_req(conv_req), .conv_offset(conv_offset),
    .raw_valid(raw_valid), .raw_data(raw_data), .slow(slow), .offs_val(offs),
    .samp_val(samp));
  ////////////////////////////////////////////////////////////////////
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (conv_req === 1'b1) nconv++;
    if (result_ready === 1'b1) nres++;
    if (cyc == 60000) begin
      miscompares++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("Compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = {8'h00, rdata};
  endtask
  // Bounded wait on busy (sel 0) or result_ready (sel 1)
  task automatic wait_for(input int sel, input logic v);
    for (int i = 0; i < 5000; i++) begin
      @(negedge clk);
      if (((sel == 1) ? result_ready : busy) === v) break;
    end
  endtask
  task automatic kick();
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [15:0] d;
    rd_reg(alpr_pkg::ADDR_PARAM, d);
    check("param reset", d, 16'h000D);
    rd_reg(alpr_pkg::ADDR_RES_HIGH, d);
    check("result high reset", d, 16'h0000);
    wr_reg(alpr_pkg::ADDR_RES_LOW, 8'hFF);
    rd_reg(alpr_pkg::ADDR_RES_LOW, d);
    check("result low read only", d, 16'h0000);
    rd_reg(8'h87, d);
    check("unmapped read", d, 16'h0000);
  endtask
  task automatic t_ondemand();
    logic [15:0] hi, lo;
    int n, s, o;
    for (int a = 0; a < 8; a++) begin
      n = (a % 2 == 0) ? 1 : 0;
      offs = (a == 6) ? 16'hFFF0 : 16'h0123;
      wr_reg(alpr_pkg::ADDR_PARAM, {1'b0, 3'h0, n[0], a[2:0]});
      rd_reg(alpr_pkg::ADDR_PARAM, hi);
      check("param readback", hi, {8'h00, 1'b0, 3'h0, n[0], a[2:0]});
      nconv = 0;
      kick();
      wait_for(1, 1'b1);
      check("conversions", 16'(nconv), 16'((1 << a) + n));
      rd_reg(alpr_pkg::ADDR_RES_HIGH, hi);
      rd_reg(alpr_pkg::ADDR_RES_LOW, lo);
      s = int'(samp) + ((a > 0) ? 1 : 0);
      o = (n == 1) ? int'(offs) : 0;
      check("result", {hi[7:0], lo[7:0]}, 16'((s > o) ? s - o : 0));
    end
  endtask
  task automatic t_cont();
    wr_reg(alpr_pkg::ADDR_PARAM, 8'h80);
    kick();
    @(negedge clk);
    nres = 0;
    repeat (40) @(negedge clk);
    check("continuous runs", 16'(nres > 3), 16'h0001);
    wr_reg(alpr_pkg::ADDR_PARAM, 8'h00);
    wait_for(0, 1'b0);
    repeat (20) @(negedge clk);
    nres = 0;
    repeat (40) @(negedge clk);
    check("runs after stop", 16'(nres), 16'h0000);
  endtask
  task automatic t_selftimed();
    int sps [8] = '{1, 2, 3, 4, 5, 6, 8, 10};
    int t0;
    slow = 1'b1;
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      st_en <= 1'b0;
      wr_reg(alpr_pkg::ADDR_PARAM, {1'b0, c[2:0], 4'h0});
      repeat (2) @(posedge clk);
      st_en <= 1'b1;
      wait_for(0, 1'b1);
      t0 = cyc;
      wait_for(0, 1'b0);
      kick();
      // Only averaging changes here, so the rate stays legal to touch
      wr_reg(alpr_pkg::ADDR_PARAM, {1'b0, c[2:0], 4'h3});
      nconv = 0;
      wait_for(0, 1'b1);
      check("period", 16'(cyc - t0), 16'(CLKHZ / sps[c]));
      wait_for(0, 1'b0);
      check("pending settings", 16'(nconv), 16'h0001);
    end
    @(posedge clk);
    st_en <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_ondemand();
    t_cont();
    t_selftimed();
    finish_test();
  end
endmodule
`default_nettype wire
